// File: common/wdt_pkg.sv
package wdt_pkg;

    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 4'h4;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_WRAP_BIT = 7;
    localparam int CTRL_MODE_BIT = 6;
    localparam int CTRL_ENABLE_BIT = 5;
    localparam int CTRL_RST_SEL_BIT = 3;
    localparam int CTRL_SEL_HI_BIT = 2;
    localparam int CTRL_SEL_MID_BIT = 1;
    localparam int CTRL_SEL_LO_BIT = 0;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;

    // ------------------------------------------------------------
    // interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_INTERVAL_BIT = 0;
    localparam int IRQ_NMI_BIT = 1;
    localparam int IRQ_RESET_BIT = 2;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    localparam int PRESC_W = 12;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 12'h000;

    typedef enum logic [2:0] {
        WDT_DIV_2,
        WDT_DIV_32,
        WDT_DIV_64,
        WDT_DIV_128,
        WDT_DIV_256,
        WDT_DIV_512,
        WDT_DIV_2048,
        WDT_DIV_4096
    } wdt_div_t;

    // divide ratio minus one for each select code
    function automatic logic [PRESC_W-1:0] wdt_div_last(input wdt_div_t s);
        case (s)
            WDT_DIV_2: wdt_div_last = 12'h001;
            WDT_DIV_32: wdt_div_last = 12'h01F;
            WDT_DIV_64: wdt_div_last = 12'h03F;
            WDT_DIV_128: wdt_div_last = 12'h07F;
            WDT_DIV_256: wdt_div_last = 12'h0FF;
            WDT_DIV_512: wdt_div_last = 12'h1FF;
            WDT_DIV_2048: wdt_div_last = 12'h7FF;
            default: wdt_div_last = 12'hFFF;
        endcase
    endfunction

endpackage

// File: verilog/wdt_prescaler.sv
`timescale 1ns/1ns
module wdt_prescaler (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_run,
    input wire wdt_pkg::wdt_div_t i_sel,
    // tick
    output logic o_tick
);
    import wdt_pkg::*;

    logic [PRESC_W-1:0] div_reg;
    logic [PRESC_W-1:0] div_next;
    logic [PRESC_W-1:0] div_last;
    logic div_hit;

    assign div_last = wdt_div_last(i_sel);
    // >= guards against a ratio lowered while counting
    assign div_hit = (div_reg >= div_last);
    assign div_next = (!i_run || div_hit) ? PRESC_RESET
                                           : div_reg + 12'h001;
    assign o_tick = i_run && div_hit;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_reg <= PRESC_RESET;
        end else begin
            div_reg <= div_next;
        end
    end

    a_tick_gap: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_tick |=> !o_tick)
        else $error("prescaler ticks on two cycles in a row");
endmodule

// File: verilog/wdt_timer.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
module wdt_timer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [wdt_pkg::ADDR_W-1:0] i_addr,
    input wire logic [wdt_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [wdt_pkg::DATA_W-1:0] o_rdata,
    // requests
    output logic o_irq,
    output logic o_nmi_req,
    output logic o_reset_req
);
    import wdt_pkg::*;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
    wire rd_ctrl = i_rd && (i_addr == ADDR_CTRL);
    wire wr_count = i_wr && (i_addr == ADDR_COUNT);
    wire wr_en = i_wr && (i_addr == ADDR_IRQ_EN);
    wire wr_clr = i_wr && (i_addr == ADDR_IRQ_CLR);

    logic mode_reg;
    logic enable_reg;
    logic rst_sel_reg;
    logic [2:0] sel_reg;
    logic wrap_reg;
    logic wrap_armed_reg;
    logic [7:0] count_reg;
    logic [IRQ_W-1:0] stat_reg;
    logic [IRQ_W-1:0] irq_en_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic nmi_reg;
    logic reset_reg;

    // ------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------
    logic tick;

    wdt_prescaler u_presc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(enable_reg),
        .i_sel(wdt_div_t'(sel_reg)),
        .o_tick(tick)
    );

    // a count write in the same cycle wins, so no wrap happens then
    wire overflow = tick && (count_reg == COUNT_MAX) && !wr_count;
    logic [7:0] count_next;
    // a software write to the count wins over a tick in the same cycle
    assign count_next = !enable_reg ? COUNT_RESET :
                        wr_count ? i_wdata :
                        tick ? count_reg + 8'h01 :
                        count_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_reg <= COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------
    // control register and wrap flag
    // ------------------------------------------------------------
    // clear needs a read that saw the flag at one first
    wire wrap_clear = wr_ctrl && wrap_armed_reg &&
                      !i_wdata[CTRL_WRAP_BIT];
    logic wrap_next;
    assign wrap_next = overflow ? 1'b1 :
                       wrap_clear ? 1'b0 : wrap_reg;
    logic armed_next;
    assign armed_next = (rd_ctrl && wrap_reg) ? 1'b1 :
                        (wrap_clear || !wrap_reg) ? 1'b0 :
                        wrap_armed_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_reg <= CTRL_RESET[CTRL_MODE_BIT];
            enable_reg <= CTRL_RESET[CTRL_ENABLE_BIT];
            rst_sel_reg <= CTRL_RESET[CTRL_RST_SEL_BIT];
            sel_reg <= CTRL_RESET[CTRL_SEL_HI_BIT:CTRL_SEL_LO_BIT];
            wrap_reg <= CTRL_RESET[CTRL_WRAP_BIT];
            wrap_armed_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                mode_reg <= i_wdata[CTRL_MODE_BIT];
                enable_reg <= i_wdata[CTRL_ENABLE_BIT];
                rst_sel_reg <= i_wdata[CTRL_RST_SEL_BIT];
                sel_reg <= i_wdata[CTRL_SEL_HI_BIT:CTRL_SEL_LO_BIT];
            end
            wrap_reg <= wrap_next;
            wrap_armed_reg <= armed_next;
        end
    end

    // ------------------------------------------------------------
    // overflow requests
    // ------------------------------------------------------------
    wire ovf_interval = overflow && !mode_reg;
    wire ovf_nmi = overflow && mode_reg && !rst_sel_reg;
    wire ovf_reset = overflow && mode_reg && rst_sel_reg;

    logic [IRQ_W-1:0] ev;
    assign ev = {ovf_reset, ovf_nmi, ovf_interval};
    logic [IRQ_W-1:0] stat_next;
    // a new event beats a clear written in the same cycle
    assign stat_next = ev | (stat_reg & ~(wr_clr ? i_wdata[IRQ_W-1:0]
                                                 : {IRQ_W{1'b0}}));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stat_reg <= {IRQ_W{1'b0}};
            irq_en_reg <= {IRQ_W{1'b0}};
            nmi_reg <= 1'b0;
            reset_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            if (wr_en) begin
                irq_en_reg <= i_wdata[IRQ_W-1:0];
            end
            nmi_reg <= ovf_nmi;
            reset_reg <= ovf_reset;
        end
    end

    assign o_irq = |(stat_reg & irq_en_reg);
    assign o_nmi_req = nmi_reg;
    assign o_reset_req = reset_reg;

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    logic [DATA_W-1:0] ctrl_view;
    assign ctrl_view = {wrap_reg, mode_reg, enable_reg, 1'b0,
                        rst_sel_reg, sel_reg};
    logic [DATA_W-1:0] rd_mux;
    assign rd_mux = (i_addr == ADDR_CTRL) ? ctrl_view :
                    (i_addr == ADDR_COUNT) ? count_reg :
                    (i_addr == ADDR_IRQ_STAT) ? {5'h00, stat_reg} :
                    (i_addr == ADDR_IRQ_EN) ? {5'h00, irq_en_reg} :
                    8'h00;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= i_rd ? rd_mux : 8'h00;
        end
    end
    assign o_rdata = rdata_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // cycles since the last tick; a control write restarts the watch
    logic [PRESC_W:0] gap_reg;
    logic [PRESC_W:0] gap_next;
    logic gap_valid_reg;
    logic gap_valid_next;

    // ratios kept apart from the prescaler's own table on purpose
    function automatic logic [PRESC_W:0] div_ratio(input logic [2:0] s);
        case (s)
            3'h0: div_ratio = 13'h0002;
            3'h1: div_ratio = 13'h0020;
            3'h2: div_ratio = 13'h0040;
            3'h3: div_ratio = 13'h0080;
            3'h4: div_ratio = 13'h0100;
            3'h5: div_ratio = 13'h0200;
            3'h6: div_ratio = 13'h0800;
            default: div_ratio = 13'h1000;
        endcase
    endfunction

    assign gap_next = (!enable_reg || tick) ? {(PRESC_W+1){1'b0}}
                                            : gap_reg + 13'h0001;
    assign gap_valid_next = (!enable_reg || wr_ctrl) ? 1'b0 :
                            tick ? 1'b1 : gap_valid_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gap_reg <= {(PRESC_W+1){1'b0}};
            gap_valid_reg <= 1'b0;
        end else begin
            gap_reg <= gap_next;
            gap_valid_reg <= gap_valid_next;
        end
    end

    // ------------------------------------------------------------
    // counter and prescaler properties
    // ------------------------------------------------------------
    a_tick_period: assert property (
        @(posedge i_clk) disable iff (i_rst)
        tick && gap_valid_reg |-> gap_reg + 13'h0001 == div_ratio(sel_reg))
        else $error("tick spacing differs from the selected ratio");

    a_div2_rate: assert property (
        @(posedge i_clk) disable iff (i_rst)
        tick && sel_reg == 3'h0 && enable_reg && !wr_ctrl ##1 !wr_ctrl
        |-> !tick ##1 tick)
        else $error("divide by two tick spacing wrong");

    a_held_zero: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !enable_reg |=> count_reg == COUNT_RESET)
        else $error("counter not held at zero while disabled");

    a_no_tick_off: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !enable_reg |-> !tick && !overflow)
        else $error("tick or overflow while disabled");

    a_count_step: assert property (
        @(posedge i_clk) disable iff (i_rst)
        enable_reg && tick && !wr_ctrl && !wr_count
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("counter did not step by one");

    a_count_hold: assert property (
        @(posedge i_clk) disable iff (i_rst)
        enable_reg && !tick && !wr_ctrl && !wr_count
        |=> $stable(count_reg))
        else $error("counter moved without a tick");

    a_count_load: assert property (
        @(posedge i_clk) disable iff (i_rst)
        enable_reg && wr_count |=> count_reg == $past(i_wdata))
        else $error("count write while running not loaded");

    // ------------------------------------------------------------
    // wrap flag properties
    // ------------------------------------------------------------
    a_wrap_set: assert property (
        @(posedge i_clk) disable iff (i_rst)
        overflow |=> wrap_reg && count_reg == COUNT_RESET)
        else $error("wrap flag not set on overflow");

    a_wrap_spurious: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !wrap_reg && !overflow |=> !wrap_reg)
        else $error("wrap flag set without an overflow");

    a_wrap_noread: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wrap_reg && !wrap_armed_reg && !rd_ctrl |=> wrap_reg)
        else $error("wrap flag cleared without a prior read");

    a_wrap_clear: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wrap_reg && rd_ctrl ##1 !overflow ##[0:1] (wr_ctrl
        && !i_wdata[CTRL_WRAP_BIT] && !overflow) |=> !wrap_reg)
        else $error("wrap flag not cleared by read then zero write");

    a_wrap_armed: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wrap_armed_reg |-> wrap_reg)
        else $error("clear armed while the wrap flag is low");

    a_wrap_read: assert property (
        @(posedge i_clk) disable iff (i_rst)
        rd_ctrl |=> o_rdata[CTRL_WRAP_BIT] == $past(wrap_reg))
        else $error("control read does not show the wrap flag");

    // ------------------------------------------------------------
    // request properties
    // ------------------------------------------------------------
    a_interval_req: assert property (
        @(posedge i_clk) disable iff (i_rst)
        overflow && !mode_reg |=> stat_reg[IRQ_INTERVAL_BIT]
        && !o_nmi_req && !o_reset_req)
        else $error("interval overflow request wrong");

    a_stat_sticky: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !wr_clr |=> (stat_reg & $past(stat_reg)) == $past(stat_reg))
        else $error("status bit fell without a clear");

    a_irq_level: assert property (
        @(posedge i_clk) disable iff (i_rst)
        stat_reg[IRQ_INTERVAL_BIT] && irq_en_reg[IRQ_INTERVAL_BIT]
        |-> o_irq)
        else $error("enabled interval status without interrupt");

    a_irq_masked: assert property (
        @(posedge i_clk) disable iff (i_rst)
        irq_en_reg == {IRQ_W{1'b0}} |-> !o_irq)
        else $error("interrupt raised with all sources masked");

    a_wdt_nmi: assert property (
        @(posedge i_clk) disable iff (i_rst)
        overflow && mode_reg && !rst_sel_reg |=> o_nmi_req
        && !o_reset_req)
        else $error("watchdog nmi request wrong");

    a_nmi_stat: assert property (
        @(posedge i_clk) disable iff (i_rst)
        ovf_nmi |=> stat_reg[IRQ_NMI_BIT])
        else $error("nmi status not set on watchdog overflow");

    a_nmi_pulse: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_nmi_req |=> !o_nmi_req)
        else $error("nmi request longer than one cycle");

    a_wdt_reset: assert property (
        @(posedge i_clk) disable iff (i_rst)
        overflow && mode_reg && rst_sel_reg |=> o_reset_req
        && !o_nmi_req)
        else $error("watchdog reset request wrong");

    a_reset_stat: assert property (
        @(posedge i_clk) disable iff (i_rst)
        ovf_reset |=> stat_reg[IRQ_RESET_BIT])
        else $error("reset status not set on watchdog overflow");

    a_reset_pulse: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_reset_req |=> !o_reset_req)
        else $error("reset request longer than one cycle");

    c_interval: cover property (@(posedge i_clk) disable iff (i_rst)
        ovf_interval);
    c_nmi: cover property (@(posedge i_clk) disable iff (i_rst)
        ovf_nmi);
    c_reset: cover property (@(posedge i_clk) disable iff (i_rst)
        ovf_reset);
    c_wrap_clr: cover property (@(posedge i_clk) disable iff (i_rst)
        wrap_clear && wrap_reg);
    c_slow_tick: cover property (@(posedge i_clk) disable iff (i_rst)
        tick && sel_reg == 3'h7);
endmodule

// File: verification/wdt_timer_bench.sv
`timescale 1ns/1ns
module wdt_timer_bench;
    import wdt_pkg::*;
    // ------------------------------------------------------------
    // stimulus, design and monitors
    // ------------------------------------------------------------
    logic i_clk;
    logic i_rst;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [DATA_W-1:0] o_rdata;
    logic o_irq;
    logic o_nmi_req;
    logic o_reset_req;
    wire logic [2:0] req_vec;
    int fail_count;
    int comparisons;
    logic [7:0] rdv;
    logic saw_nmi;
    logic saw_rst;
    int ratio [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

    assign req_vec = {o_reset_req, o_nmi_req, o_irq};

    wdt_timer dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_irq(o_irq), .o_nmi_req(o_nmi_req), .o_reset_req(o_reset_req));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // pulses last one cycle, so latch them for later judging
    // mid-cycle, where the registered pulse has settled
    always @(negedge i_clk) begin
        if (o_nmi_req === 1'b1) saw_nmi = 1'b1;
        if (o_reset_req === 1'b1) saw_rst = 1'b1;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic wait_req(input int which, input int limit);
        int n;
        n = 0;
        while (req_vec[which] !== 1'b1) begin
            @(posedge i_clk);
            #1;
            n++;
            if (n > limit) begin
                check({7'h00, req_vec[which]}, 8'h01);
                end_of_test();
            end
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        rd(ADDR_CTRL, rdv);
        check(rdv, 8'h00);
        rd(ADDR_IRQ_STAT, rdv);
        check(rdv, 8'h00);
        rd(ADDR_IRQ_EN, rdv);
        check(rdv, 8'h00);
        wr(ADDR_COUNT, 8'h55);
        wr(4'hF, 8'hFF);
        repeat (10) @(posedge i_clk);
        rd(ADDR_COUNT, rdv);
        check(rdv, 8'h00);
        rd(4'hF, rdv);
        check(rdv, 8'h00);
        rd(ADDR_IRQ_CLR, rdv);
        check(rdv, 8'h00);
        $display("test reset done");
    endtask

    // sample mid-way between ticks, except at divide by two, where the read sees the count in the first cycle after its fourth step
    task automatic test_prescale();
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_CTRL, 8'h20 | 8'(s));
            repeat (4 * ratio[s] + ratio[s] / 2 - 2) @(posedge i_clk);
            rd(ADDR_COUNT, rdv);
            check(rdv, 8'h04);
            wr(ADDR_CTRL, 8'h00);
            rd(ADDR_COUNT, rdv);
            check(rdv, 8'h00);
        end
        $display("test prescale done");
    endtask

    task automatic test_interval();
        saw_nmi = 1'b0;
        saw_rst = 1'b0;
        wr(ADDR_CTRL, 8'h20);
        wr(ADDR_COUNT, 8'hF0);
        repeat (60) @(posedge i_clk);
        #1;
        check({7'h00, o_irq}, 8'h00);
        rd(ADDR_IRQ_STAT, rdv);
        check(rdv, 8'h01);
        wr(ADDR_IRQ_EN, 8'h01);
        #1;
        check({7'h00, o_irq}, 8'h01);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, rdv);
        check(rdv, 8'h80);
        wr(ADDR_CTRL, 8'h80);
        rd(ADDR_CTRL, rdv);
        check(rdv, 8'h80);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, rdv);
        check(rdv, 8'h00);
        wr(ADDR_IRQ_STAT, 8'h00);
        rd(ADDR_IRQ_STAT, rdv);
        check(rdv, 8'h01);
        wr(ADDR_IRQ_CLR, 8'h01);
        #1;
        check({7'h00, o_irq}, 8'h00);
        check({6'h00, saw_nmi, saw_rst}, 8'h00);
        $display("test interval done");
    endtask

    task automatic test_watchdog();
        for (int rs = 0; rs < 2; rs++) begin
            saw_nmi = 1'b0;
            saw_rst = 1'b0;
            wr(ADDR_CTRL, 8'h60 | 8'(rs << CTRL_RST_SEL_BIT));
            wr(ADDR_COUNT, 8'hF0);
            wait_req(1 + rs, 100);
            @(posedge i_clk);
            #1;
            check({7'h00, rs ? saw_nmi : saw_rst}, 8'h00);
            rd(ADDR_IRQ_STAT, rdv);
            check(rdv, 8'(1 << (IRQ_NMI_BIT + rs)));
            wr(ADDR_CTRL, 8'h00);
            wr(ADDR_IRQ_CLR, 8'h07);
        end
        $display("test watchdog done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        comparisons = 0;
        saw_nmi = 1'b0;
        saw_rst = 1'b0;
        i_rst = 1'b1;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        test_reset();
        test_prescale();
        test_interval();
        test_watchdog();
        end_of_test();
    end
endmodule
